/* pkg/ddsl_pkg.sv */
package ddsl_pkg;

    // width of one channel code and of the serial shift register
    localparam int CODE_W = 12;

    // number of converter channels fed from the common shift register
    localparam int CHAN_N = 2;

    // default depth of the crossing buffer between serial clock and core clock
    localparam int FIFO_DEPTH = 8;

    // preset codes selected by the half-scale input while the preset pin is low
    localparam logic [CODE_W-1:0] HALF_SCALE_CODE = 12'h800;
    localparam logic [CODE_W-1:0] ZERO_SCALE_CODE = 12'h000;

    // values taken under the core reset
    localparam logic [CODE_W-1:0] CHAN_RST_CODE = 12'h000;
    localparam logic [CODE_W-1:0] MIRROR_RST_CODE = 12'h000;

    // bit positions of the pin levels inside the synchronised control vector
    localparam int CTL_LOAD_A = 0;
    localparam int CTL_LOAD_B = 1;
    localparam int CTL_PRESET = 2;
    localparam int CTL_HALF = 3;
    localparam int CTL_PDOWN = 4;
    localparam int CTL_W = 5;

endpackage

/* src/ddsl_sync.sv */
`timescale 1ns/1ps
module ddsl_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_in,                 // destination clock
    input wire logic [WIDTH-1:0] async_in,   // level from another domain
    output logic [WIDTH-1:0] sync_out        // level after two flip-flops
);

    logic [WIDTH-1:0] stage1_ff;
    logic [WIDTH-1:0] stage2_ff;
    logic [WIDTH-1:0] nxt_stage1;
    logic [WIDTH-1:0] nxt_stage2;

    // first stage feeds only the second stage
    always_comb begin
        nxt_stage1 = async_in;
        nxt_stage2 = stage1_ff;
    end

    // two-stage synchroniser, no reset so it never blocks a level
    always_ff @(posedge clk_in) begin
        stage1_ff <= nxt_stage1;
        stage2_ff <= nxt_stage2;
    end

    assign sync_out = stage2_ff;

endmodule

/* src/ddsl_fifo.sv */
`timescale 1ns/1ps
module ddsl_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 8
) (
    input wire logic wr_clk_in,              // filling side clock
    input wire logic wr_rst_n_in,            // filling side reset, synchronous
    input wire logic wr_valid_in,            // word offered
    input wire logic [WIDTH-1:0] wr_data_in, // word to store
    output logic wr_ready_out,               // room for a word
    input wire logic rd_clk_in,              // draining side clock
    input wire logic rd_rst_n_in,            // draining side reset, synchronous
    input wire logic rd_ready_in,            // drain accepts a word
    output logic rd_valid_out,               // word present on rd_data_out
    output logic [WIDTH-1:0] rd_data_out     // oldest word, registered
);

    localparam int AW = $clog2(DEPTH);

    // gray full test needs at least two address bits and a power-of-two depth
    if (DEPTH < 4 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("ddsl_fifo depth must be a power of two of at least 4");
    end
    if (WIDTH < 1) begin : g_bad_width
        $error("ddsl_fifo width must be at least 1");
    end

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW:0] wbin_ff;
    logic [AW:0] wgray_ff;
    logic wready_ff;
    logic [AW:0] nxt_wbin;
    logic [AW:0] nxt_wgray;
    logic nxt_wready;
    logic push;
    logic [AW:0] rgray_at_wr;
    logic [AW:0] rbin_ff;
    logic [AW:0] rgray_ff;
    logic rempty_ff;
    logic rvalid_ff;
    logic [WIDTH-1:0] rdata_ff;
    logic [AW:0] nxt_rbin;
    logic [AW:0] nxt_rgray;
    logic nxt_rempty;
    logic nxt_rvalid;
    logic [WIDTH-1:0] nxt_rdata;
    logic pop;
    logic [AW:0] wgray_at_rd;

    // read pointer brought into the write domain
    ddsl_sync #(.WIDTH(AW + 1)) u_rptr_sync (
        .clk_in(wr_clk_in),
        .async_in(rgray_ff),
        .sync_out(rgray_at_wr)
    );

    // write pointer brought into the read domain
    ddsl_sync #(.WIDTH(AW + 1)) u_wptr_sync (
        .clk_in(rd_clk_in),
        .async_in(wgray_ff),
        .sync_out(wgray_at_rd)
    );

    // write pointer and full test on the next pointer value
    always_comb begin
        push = wr_valid_in && wready_ff;
        nxt_wbin = wbin_ff + {{AW{1'b0}}, push};
        nxt_wgray = (nxt_wbin >> 1) ^ nxt_wbin;
        nxt_wready = nxt_wgray != {~rgray_at_wr[AW:AW-1], rgray_at_wr[AW-2:0]};
    end

    // write side state, not ready while in reset
    always_ff @(posedge wr_clk_in) begin
        if (!wr_rst_n_in) begin
            wbin_ff <= '0;
            wgray_ff <= '0;
            wready_ff <= 1'b0;
        end else begin
            wbin_ff <= nxt_wbin;
            wgray_ff <= nxt_wgray;
            wready_ff <= nxt_wready;
        end
    end

    // storage, written only from the write domain
    always_ff @(posedge wr_clk_in) begin
        if (push) begin
            mem_ff[wbin_ff[AW-1:0]] <= wr_data_in;
        end
    end

    // read pointer, empty test and output register refill
    always_comb begin
        pop = !rempty_ff && (!rvalid_ff || rd_ready_in);
        nxt_rbin = rbin_ff + {{AW{1'b0}}, pop};
        nxt_rgray = (nxt_rbin >> 1) ^ nxt_rbin;
        nxt_rempty = nxt_rgray == wgray_at_rd;
        nxt_rvalid = pop ? 1'b1 : (rd_ready_in ? 1'b0 : rvalid_ff);
        nxt_rdata = pop ? mem_ff[rbin_ff[AW-1:0]] : rdata_ff;
    end

    // read side state
    always_ff @(posedge rd_clk_in) begin
        if (!rd_rst_n_in) begin
            rbin_ff <= '0;
            rgray_ff <= '0;
            rempty_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rdata_ff <= '0;
        end else begin
            rbin_ff <= nxt_rbin;
            rgray_ff <= nxt_rgray;
            rempty_ff <= nxt_rempty;
            rvalid_ff <= nxt_rvalid;
            rdata_ff <= nxt_rdata;
        end
    end

    assign wr_ready_out = wready_ff;
    assign rd_valid_out = rvalid_ff;
    assign rd_data_out = rdata_ff;

endmodule

/* src/ddsl_top.sv */
// Behaviour
// - shifting happens only while chip select is low; strobes ignore chip select
// - each serial clock rising edge with select low and the buffer ready shifts in one data bit
// - low first load strobe copies the shift register into channel A
// - low second load strobe copies the shift register into channel B
// - channel updates on strobe fall, follows while low, holds while high
// - preset low with half-scale high loads both channels with 800 hex
// - preset low with half-scale low clears both channels to 000 hex
// - preset overrides strobes and clocks, and leaves the shift register alone
// - power down input changes neither shift register nor channel registers
`timescale 1ns/1ps
module ddsl_top #(
    parameter int FIFO_WORDS = ddsl_pkg::FIFO_DEPTH
) (
    input wire logic ref_clk_in,                            // core clock, 20 mhz
    input wire logic reset_n_in,                            // core reset, active low
    input wire logic serial_clk_in,                         // serial clock from host
    input wire logic chip_select_n_in,                      // chip select, active low
    input wire logic serial_in,                             // serial data bit
    input wire logic load_strobe_chan_a_n_in,               // channel a load, active low
    input wire logic load_strobe_chan_b_n_in,               // channel b load, active low
    input wire logic async_preset_n_in,                     // channel preset, active low
    input wire logic half_scale_sel_in,                     // preset to half scale when high
    input wire logic power_down_n_in,                       // shutdown, active low
    output logic [ddsl_pkg::CODE_W-1:0] chan_a_code_out,    // channel a register
    output logic [ddsl_pkg::CODE_W-1:0] chan_b_code_out,    // channel b register
    output logic [ddsl_pkg::CODE_W-1:0] shift_code_out,     // shift register copy
    output logic [ddsl_pkg::CHAN_N-1:0] chan_loaded_out,    // pulse on each strobe fall while preset is high
    output logic preset_active_out,                         // preset seen low
    output logic powered_down_out,                          // shutdown seen low
    output logic shift_ready_out                            // buffer can take a shift
);
    import ddsl_pkg::*;

    // buffer depth must be a power of two of at least four
    if (FIFO_WORDS < 4 || (1 << $clog2(FIFO_WORDS)) != FIFO_WORDS) begin : g_bad_words
        $error("ddsl_top fifo depth must be a power of two of at least 4");
    end

    // ---------------- serial clock domain ----------------

    logic link_rst_n;
    logic [CODE_W-1:0] shift_ff;
    logic [CODE_W-1:0] nxt_shift;
    logic shift_en;
    logic link_ready;

    // core reset carried onto the serial clock, it only steers the buffer
    ddsl_sync #(.WIDTH(1)) u_link_rst_sync (
        .clk_in(serial_clk_in),
        .async_in(reset_n_in),
        .sync_out(link_rst_n)
    );

    // one bit per rising edge while selected, msb first, stalled when full
    always_comb begin
        shift_en = !chip_select_n_in && link_ready;
        nxt_shift = shift_ff;
        if (shift_en) begin
            nxt_shift = {shift_ff[CODE_W-2:0], serial_in};
        end
    end

    // shift register, deliberately without reset so the preset never reaches it
    always_ff @(posedge serial_clk_in) begin
        shift_ff <= nxt_shift;
    end

    // ---------------- crossing into the core clock ----------------

    logic [CODE_W-1:0] fifo_data;
    logic fifo_valid;
    logic fifo_ready;

    // every shifted value is queued so the core copy tracks the shift register
    ddsl_fifo #(.WIDTH(CODE_W), .DEPTH(FIFO_WORDS)) u_fifo (
        .wr_clk_in(serial_clk_in),
        .wr_rst_n_in(link_rst_n),
        .wr_valid_in(shift_en),
        .wr_data_in(nxt_shift),
        .wr_ready_out(link_ready),
        .rd_clk_in(ref_clk_in),
        .rd_rst_n_in(reset_n_in),
        .rd_ready_in(fifo_ready),
        .rd_valid_out(fifo_valid),
        .rd_data_out(fifo_data)
    );

    // ---------------- core clock domain ----------------

    logic [CTL_W-1:0] ctl_pins;
    logic [CTL_W-1:0] ctl_sync;
    logic load_a_n;
    logic load_b_n;
    logic preset_n;
    logic half_sel;
    logic pdown_n;

    // all control pins pass two flip-flops before use
    assign ctl_pins[CTL_LOAD_A] = load_strobe_chan_a_n_in;
    assign ctl_pins[CTL_LOAD_B] = load_strobe_chan_b_n_in;
    assign ctl_pins[CTL_PRESET] = async_preset_n_in;
    assign ctl_pins[CTL_HALF] = half_scale_sel_in;
    assign ctl_pins[CTL_PDOWN] = power_down_n_in;

    ddsl_sync #(.WIDTH(CTL_W)) u_ctl_sync (
        .clk_in(ref_clk_in),
        .async_in(ctl_pins),
        .sync_out(ctl_sync)
    );

    // named views of the synchronised levels
    assign load_a_n = ctl_sync[CTL_LOAD_A];
    assign load_b_n = ctl_sync[CTL_LOAD_B];
    assign preset_n = ctl_sync[CTL_PRESET];
    assign half_sel = ctl_sync[CTL_HALF];
    assign pdown_n = ctl_sync[CTL_PDOWN];

    logic [CODE_W-1:0] mirror_ff;
    logic [CODE_W-1:0] nxt_mirror;
    logic preset_ff;
    logic nxt_preset;
    logic pdown_ff;
    logic nxt_pdown;

    // drain is held while preset is low; queued shifts catch up afterwards
    assign fifo_ready = preset_n;

    // core copy of the shift register, untouched by preset and power down
    always_comb begin
        nxt_mirror = mirror_ff;
        if (fifo_valid && fifo_ready) begin
            nxt_mirror = fifo_data;
        end
        nxt_preset = !preset_n;
        nxt_pdown = !pdown_n;
    end

    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            mirror_ff <= MIRROR_RST_CODE;
            preset_ff <= 1'b0;
            pdown_ff <= 1'b0;
        end else begin
            mirror_ff <= nxt_mirror;
            preset_ff <= nxt_preset;
            pdown_ff <= nxt_pdown;
        end
    end

    logic [CHAN_N-1:0] strobe_n;
    logic [CODE_W-1:0] chan_code [CHAN_N];
    logic [CHAN_N-1:0] loaded;

    // strobe per channel: index 0 is channel a, index 1 is channel b
    assign strobe_n[0] = load_a_n;
    assign strobe_n[1] = load_b_n;

    // one channel register per strobe, preset first, then strobe, else hold
    for (genvar ch = 0; ch < CHAN_N; ch++) begin : g_chan
        logic [CODE_W-1:0] code_ff;
        logic [CODE_W-1:0] nxt_code;
        logic strobe_prev_ff;
        logic nxt_strobe_prev;
        logic loaded_ff;
        logic nxt_loaded;

        always_comb begin
            nxt_code = code_ff;
            nxt_strobe_prev = strobe_n[ch];
            nxt_loaded = preset_n && strobe_prev_ff && !strobe_n[ch];
            if (!preset_n) begin
                nxt_code = half_sel ? HALF_SCALE_CODE : ZERO_SCALE_CODE;
            end else if (!strobe_n[ch]) begin
                nxt_code = mirror_ff;
            end
        end

        always_ff @(posedge ref_clk_in) begin
            if (!reset_n_in) begin
                code_ff <= CHAN_RST_CODE;
                strobe_prev_ff <= 1'b1;
                loaded_ff <= 1'b0;
            end else begin
                code_ff <= nxt_code;
                strobe_prev_ff <= nxt_strobe_prev;
                loaded_ff <= nxt_loaded;
            end
        end

        assign chan_code[ch] = code_ff;
        assign loaded[ch] = loaded_ff;
    end

    // all outputs come straight from flip-flops
    assign chan_a_code_out = chan_code[0];
    assign chan_b_code_out = chan_code[1];
    assign shift_code_out = mirror_ff;
    assign chan_loaded_out = loaded;
    assign preset_active_out = preset_ff;
    assign powered_down_out = pdown_ff;
    assign shift_ready_out = link_ready;

endmodule

/* test/ddsl_host_model.sv */
`timescale 1ns/1ps
module ddsl_host_model (
    input wire logic run_in,          // keep the clock running between frames
    input wire logic go_in,           // start one word
    input wire logic [11:0] word_in,  // word to send
    input wire logic ready_in,        // device buffer has room
    output logic sclk_out,            // serial clock
    output logic cs_n_out,            // chip select, active low
    output logic ser_data_out,        // serial data
    output logic done_out             // last word fully sent
);
    logic busy = 1'b0;
    // clock stands still outside frames unless asked to run
    initial begin
        sclk_out = 1'b0;
        #7;
        forever begin
            #40;
            sclk_out = (run_in || busy) ? ~sclk_out : 1'b0;
        end
    end
    // twelve bits, msb first, changed on the falling edge; waits while the buffer is full
    initial begin
        cs_n_out = 1'b1;
        ser_data_out = 1'b0;
        done_out = 1'b1;
        forever begin
            @(posedge go_in);
            busy = 1'b1;
            done_out = 1'b0;
            for (int i = 11; i >= 0; i--) begin
                @(negedge sclk_out);
                while (!ready_in) @(negedge sclk_out);
                cs_n_out = 1'b0;
                ser_data_out = word_in[i];
            end
            @(negedge sclk_out);
            cs_n_out = 1'b1;
            ser_data_out = ~ser_data_out; // released line does not keep the last bit
            busy = 1'b0;
            done_out = 1'b1;
        end
    end
endmodule

/* test/ddsl_top_sva.sv */
`timescale 1ns/1ps
module ddsl_top_sva #(
    parameter int FIFO_WORDS = 8
) (
    input wire logic ref_clk_in,                          // core clock
    input wire logic reset_n_in,                          // core reset
    input wire logic chip_select_n_in,                    // chip select
    input wire logic load_strobe_chan_a_n_in,             // load a
    input wire logic load_strobe_chan_b_n_in,             // load b
    input wire logic async_preset_n_in,                   // preset
    input wire logic half_scale_sel_in,                   // half scale select
    input wire logic power_down_n_in,                     // shutdown
    input wire logic [ddsl_pkg::CODE_W-1:0] chan_a_code_out, // channel a
    input wire logic [ddsl_pkg::CODE_W-1:0] chan_b_code_out, // channel b
    input wire logic [ddsl_pkg::CODE_W-1:0] shift_code_out,  // shift copy
    input wire logic [ddsl_pkg::CHAN_N-1:0] chan_loaded_out, // load pulses
    input wire logic preset_active_out,                   // preset flag
    input wire logic powered_down_out                     // shutdown flag
);
    import ddsl_pkg::*;
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);
    a_preset_half: assert property (
        preset_active_out && $past(half_scale_sel_in, 2) && $past(half_scale_sel_in, 3)
        |-> chan_a_code_out == HALF_SCALE_CODE && chan_b_code_out == HALF_SCALE_CODE)
        else $error("half scale preset wrong");
    a_preset_zero: assert property (
        preset_active_out && !$past(half_scale_sel_in, 2) && !$past(half_scale_sel_in, 3)
        |-> chan_a_code_out == ZERO_SCALE_CODE && chan_b_code_out == ZERO_SCALE_CODE)
        else $error("zero preset wrong");
    a_preset_no_load: assert property (preset_active_out |-> chan_loaded_out == 2'h0)
        else $error("load during preset");
    a_load_a_copy: assert property (chan_loaded_out[0] |-> chan_a_code_out == shift_code_out)
        else $error("channel a not loaded");
    a_load_b_copy: assert property (chan_loaded_out[1] |-> chan_b_code_out == shift_code_out)
        else $error("channel b not loaded");
    a_load_pulse_once: assert property (
        chan_loaded_out != 2'h0 |=> (chan_loaded_out & $past(chan_loaded_out)) == 2'h0)
        else $error("load pulse too long");
    a_chan_hold: assert property (
        (load_strobe_chan_a_n_in && load_strobe_chan_b_n_in && async_preset_n_in) [*4]
        |=> $stable(chan_a_code_out) && $stable(chan_b_code_out))
        else $error("channel changed while latched");
    a_pdown_flag: assert property ((!power_down_n_in) [*4] |-> powered_down_out)
        else $error("shutdown not reported");
    a_pdown_clear: assert property (power_down_n_in [*4] |-> !powered_down_out)
        else $error("shutdown flag stuck");
    a_shift_quiet: assert property (
        (chip_select_n_in && async_preset_n_in) [*8] |=> $stable(shift_code_out))
        else $error("shift changed while deselected");
    c_load_a: cover property (chan_loaded_out[0]);
    c_preset_half: cover property (preset_active_out && chan_a_code_out == HALF_SCALE_CODE);
    c_pdown: cover property (powered_down_out);
endmodule

/* test/ddsl_top_tb_top.sv */
`timescale 1ns/1ps
module ddsl_top_tb_top;
    import ddsl_pkg::*;
    logic ref_clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic run = 1'b1;
    logic go = 1'b0;
    logic strobe_a_n = 1'b1;
    logic strobe_b_n = 1'b1;
    logic pre_n = 1'b1;
    logic half = 1'b0;
    logic pd_n = 1'b1;
    logic [CODE_W-1:0] word = 12'h000;
    logic sclk, cs_n, ser_data, done, rdy, pdo, pra;
    logic [CODE_W-1:0] ca, cb, sc;
    logic [CHAN_N-1:0] ld;
    int num_errors = 0;
    int checks_done = 0;
    always #25 ref_clk_in = ~ref_clk_in;
    ddsl_top dut (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .serial_clk_in(sclk),
        .chip_select_n_in(cs_n), .serial_in(ser_data), .load_strobe_chan_a_n_in(strobe_a_n),
        .load_strobe_chan_b_n_in(strobe_b_n), .async_preset_n_in(pre_n), .half_scale_sel_in(half),
        .power_down_n_in(pd_n), .chan_a_code_out(ca), .chan_b_code_out(cb),
        .shift_code_out(sc), .chan_loaded_out(ld), .preset_active_out(pra),
        .powered_down_out(pdo), .shift_ready_out(rdy));
    ddsl_host_model host (.run_in(run), .go_in(go), .word_in(word), .ready_in(rdy),
        .sclk_out(sclk), .cs_n_out(cs_n), .ser_data_out(ser_data), .done_out(done));
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk_in);
        #2;
    endtask
    task automatic chk(input logic [CODE_W-1:0] seen, input logic [CODE_W-1:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic wait_done();
        for (int i = 0; i < 2000 && !done; i++) step(1);
        if (!done) begin
            chk(12'h001, 12'h000);
            wrap_up();
        end
        step(10);
    endtask
    // strobes only between frames, never while shifting
    task automatic load(input int b);
        if (b == 0) strobe_a_n = 1'b0;
        else strobe_b_n = 1'b0;
        step(4);
        strobe_a_n = 1'b1;
        strobe_b_n = 1'b1;
        step(4);
    endtask
    task automatic send(input logic [CODE_W-1:0] w);
        word = w;
        go = 1'b1;
        step(1);
        go = 1'b0;
        wait_done();
    endtask
    task automatic t_load();
        send(12'ha5c);
        chk(sc, 12'ha5c);
        load(0);
        chk(ca, 12'ha5c);
        chk(cb, 12'h000);
        send(12'h3b1);
        chk(ca, 12'ha5c);
        load(1);
        chk(cb, 12'h3b1);
        $display("test load done");
    endtask
    task automatic t_cs_idle();
        run = 1'b1;
        step(40);
        chk(sc, 12'h3b1);
        load(0);
        chk(ca, 12'h3b1);
        run = 1'b0;
        $display("test idle select done");
    endtask
    task automatic t_preset();
        logic [CODE_W-1:0] e;
        for (int h = 1; h >= 0; h--) begin
            half = h[0];
            e = h ? HALF_SCALE_CODE : ZERO_SCALE_CODE;
            pre_n = 1'b0;
            strobe_a_n = 1'b0;
            step(6);
            chk(ca, e);
            chk(cb, e);
            chk({11'h000, pra}, 12'h001);
            strobe_a_n = 1'b1;
            step(4);
            pre_n = 1'b1;
            step(6);
            chk(ca, e);
            chk(sc, 12'h3b1);
        end
        $display("test preset done");
    endtask
    // preset stalls the drain, so shifts fill the buffer until it refuses
    task automatic t_buffer();
        int i;
        pre_n = 1'b0;
        word = 12'h6e7;
        go = 1'b1;
        step(1);
        go = 1'b0;
        for (i = 0; i < 400 && rdy; i++) step(1);
        chk({11'h000, rdy}, 12'h000);
        if (rdy) begin
            wrap_up();
        end
        pre_n = 1'b1;
        wait_done();
        chk(sc, 12'h6e7);
        chk(ca, ZERO_SCALE_CODE);
        $display("test buffer done");
    endtask
    task automatic t_pdown();
        pd_n = 1'b0;
        step(6);
        chk({11'h000, pdo}, 12'h001);
        chk(ca, ZERO_SCALE_CODE);
        chk(sc, 12'h6e7);
        pd_n = 1'b1;
        step(6);
        chk({11'h000, pdo}, 12'h000);
        $display("test power down done");
    endtask
    initial begin
        step(8);
        reset_n_in = 1'b1;
        for (int i = 0; i < 100 && !rdy; i++) step(1);
        chk({11'h000, rdy}, 12'h001);
        if (!rdy) begin
            wrap_up();
        end
        run = 1'b0;
        t_load();
        t_cs_idle();
        t_preset();
        t_buffer();
        t_pdown();
        wrap_up();
    end
endmodule
bind ddsl_top ddsl_top_sva #(.FIFO_WORDS(FIFO_WORDS)) u_sva (.ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in), .chip_select_n_in(chip_select_n_in),
    .load_strobe_chan_a_n_in(load_strobe_chan_a_n_in),
    .load_strobe_chan_b_n_in(load_strobe_chan_b_n_in), .async_preset_n_in(async_preset_n_in),
    .half_scale_sel_in(half_scale_sel_in), .power_down_n_in(power_down_n_in),
    .chan_a_code_out(chan_a_code_out), .chan_b_code_out(chan_b_code_out),
    .shift_code_out(shift_code_out), .chan_loaded_out(chan_loaded_out),
    .preset_active_out(preset_active_out), .powered_down_out(powered_down_out));
